// *** hw/bram_core.sv ***
// Dual-port 9-Kbit embedded block RAM with configurable widths and write behaviour
//
// Function
// R1: The block stores 9 Kbit with registers on the array inputs and outputs.
// R2: It works as single port, true dual port or pseudo dual port (A writes, B reads).
// R3: Widths 1, 2, 4, 9, 18 and 36 are legal, except 36 in true dual-port mode.
// R4: Each port of a multi-port mode has its own width.
// R5: Word k of a port of width W occupies array bits k*W up to k*W+W-1, LSB first.
// R6: The array may hold preset contents from configuration before use.
// R7: Preset contents with writes held off make the block a ROM.
// R8: Address, data and controls of each port are registered on the clock edge.
// R9: Read data passes an output register that may be enabled or bypassed.
// R10: In normal mode the output changes only on reads, never on writes.
// R11: In write-through mode the written data appears on the same port output.
// R12: In read-before-write mode the old content of the address appears on write.
// R13: Output latches clear asynchronously or synchronously by configuration.
// R14: Each port has a local reset that clears only its own output latch.
// R15: The global reset clears the output latches of both ports.
// R16: Data appears one cycle after the address register, two with the output register.
// R17: Same-address access by both ports with a write gives an undefined read.
module bram_core #(
    parameter bram_pkg::bram_mode_t              MODE         = bram_pkg::MODE_TRUE_DUAL,
    parameter int                                WIDTH_A      = 9,
    parameter int                                WIDTH_B      = 9,
    parameter bit                                OUT_REG_A    = 1'b0,
    parameter bit                                OUT_REG_B    = 1'b0,
    parameter bram_pkg::bram_wmode_t             WRITE_MODE_A = bram_pkg::WR_NORMAL,
    parameter bram_pkg::bram_wmode_t             WRITE_MODE_B = bram_pkg::WR_NORMAL,
    parameter bit                                SYNC_RESET   = 1'b0,
    parameter logic [bram_pkg::MEM_BITS-1:0]     INIT_BITS    = '0
) (
    // Clock and system reset
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_i,
    // Output latch resets
    input  wire logic                          global_set_reset_n_i,
    input  wire logic                          port_a_output_reset_i,
    input  wire logic                          port_b_output_reset_i,
    // Port requests
    input  wire bram_pkg::bram_req_t           port_a_req_i,
    input  wire bram_pkg::bram_req_t           port_b_req_i,
    // Read data
    output logic [bram_pkg::DATA_W-1:0]        port_a_rdata_o,
    output logic [bram_pkg::DATA_W-1:0]        port_b_rdata_o
);
    import bram_pkg::*;

    // ------------------------------------------------------------
    // Configuration tables and elaboration check
    // ------------------------------------------------------------
    localparam int          WID  [2] = '{WIDTH_A, WIDTH_B};
    localparam bit          OREG [2] = '{OUT_REG_A, OUT_REG_B};
    localparam bram_wmode_t WMODE[2] = '{WRITE_MODE_A, WRITE_MODE_B};

    // Port B takes part only in the two multi-port modes
    localparam bit B_USED = (MODE != MODE_SINGLE);
    localparam bit BAD_A  = !bram_width_ok(WIDTH_A);
    localparam bit BAD_B  = B_USED && !bram_width_ok(WIDTH_B);
    localparam bit BAD_TD = (MODE == MODE_TRUE_DUAL) && ((WIDTH_A == 36) || (WIDTH_B == 36));

    if (BAD_A || BAD_B || BAD_TD) begin : g_bad_cfg
        $error("bram_core: unsupported width or width/mode pairing");  // [R3]
    end

    // Pseudo dual port: A only writes, B only reads
    localparam bit RD_OK[2] = '{MODE != MODE_PSEUDO_DUAL, B_USED};  // [R2]
    localparam bit WR_OK[2] = '{1'b1, MODE == MODE_TRUE_DUAL};      // [R2]

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Preset at configuration; no reset touches the array itself
    logic [MEM_BITS-1:0] mem_q = INIT_BITS;                         // [R1] [R6] [R7]

    // ------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------
    bram_req_t req_in [2];
    bram_req_t req_q  [2];

    assign req_in[0] = port_a_req_i;
    assign req_in[1] = port_b_req_i;

    // ------------------------------------------------------------
    // Per-port access and output path
    // ------------------------------------------------------------
    logic [BIT_IDX_W-1:0] idx_w  [2];
    logic                 wr_go  [2];
    logic                 load_w [2];
    logic [DATA_W-1:0]    ldata_w[2];
    logic [DATA_W-1:0]    rdata_w[2];
    logic                 clr_w  [2];

    assign clr_w[0] = port_a_output_reset_i | ~global_set_reset_n_i;  // [R14] [R15]
    assign clr_w[1] = port_b_output_reset_i | ~global_set_reset_n_i;  // [R14] [R15]

    for (genvar p = 0; p < 2; p++) begin : g_port
        localparam int MASK = bram_depth(WID[p]) - 1;

        logic [DATA_W-1:0] old_w;
        logic [DATA_W-1:0] thru_w;
        logic              rd_go;

        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                req_q[p] <= '0;
            end else begin
                req_q[p] <= req_in[p];                              // [R8]
            end
        end

        // Address beyond the organisation depth wraps inside the array
        assign idx_w[p] = BIT_IDX_W'((int'(req_q[p].addr) & MASK) * WID[p]);  // [R5] [R4]
        assign old_w    = DATA_W'(mem_q[idx_w[p] +: WID[p]]);       // [R5]
        assign thru_w   = DATA_W'(req_q[p].wdata[WID[p]-1:0]);
        assign rd_go    = req_q[p].en & ~req_q[p].we & RD_OK[p];
        assign wr_go[p] = req_q[p].en & req_q[p].we & WR_OK[p];

        // Normal mode leaves the latch alone on writes
        assign load_w[p]  = rd_go | (wr_go[p] & (WMODE[p] != WR_NORMAL));      // [R10]
        // Old data is still in the array on the write edge
        assign ldata_w[p] = (wr_go[p] && (WMODE[p] == WR_THROUGH)) ? thru_w    // [R11]
                                                                   : old_w;    // [R12]

        bram_out_stage #(
            .W          (DATA_W),
            .OUT_REG    (OREG[p]),
            .SYNC_RESET (SYNC_RESET)
        ) u_out (
            .clk_i  (ref_clk_i),
            .rst_i  (rst_i),
            .clr_i  (clr_w[p]),
            .load_i (load_w[p]),
            .data_i (ldata_w[p]),
            .data_o (rdata_w[p])
        );                                                          // [R9] [R13] [R16]
    end

    // ------------------------------------------------------------
    // Array write
    // ------------------------------------------------------------
    // Port B is applied last, so it wins a same-address double write
    always_ff @(posedge ref_clk_i) begin
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < DATA_W; i++) begin
                if (wr_go[p] && (i < WID[p])) begin
                    mem_q[BIT_IDX_W'(int'(idx_w[p]) + i)] <= req_q[p].wdata[i];  // [R5]
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign port_a_rdata_o = rdata_w[0];
    assign port_b_rdata_o = rdata_w[1];

endmodule

// *** hw/bram_pkg.sv ***
// Shared constants, types and helper functions for the 9-Kbit block RAM
package bram_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int MEM_BITS    = 9216;  // 9 Kbit including parity-width organisations
    localparam int NARROW_BITS = 8192;  // Usable bits for the x1, x2 and x4 organisations
    localparam int ADDR_W      = 13;    // Enough for the deepest organisation (8192 words)
    localparam int DATA_W      = 36;    // Widest organisation
    localparam int BIT_IDX_W   = 14;    // Bit index into the array
    localparam int WIDE_MIN    = 9;     // Widths from here upward use the full array

    // ------------------------------------------------------------
    // Configuration choices
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_TRUE_DUAL,
        MODE_PSEUDO_DUAL
    } bram_mode_t;

    typedef enum logic [1:0] {
        WR_NORMAL,
        WR_THROUGH,
        WR_READ_BEFORE
    } bram_wmode_t;

    // ------------------------------------------------------------
    // Per-port request from the fabric
    // ------------------------------------------------------------
    typedef struct packed {
        logic              en;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bram_req_t;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic bit bram_width_ok(input int w);
        return (w == 1) || (w == 2) || (w == 4) || (w == 9) || (w == 18) || (w == 36);
    endfunction

    function automatic int bram_depth(input int w);
        return ((w >= WIDE_MIN) ? MEM_BITS : NARROW_BITS) / w;
    endfunction

endpackage

// *** hw/bram_out_stage.sv ***
// Output latch and optional output register of one block RAM port
module bram_out_stage #(
    parameter int W          = 36,
    parameter bit OUT_REG    = 1'b0,
    parameter bit SYNC_RESET = 1'b0
) (
    // Clock and resets
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         clr_i,
    // Data from the array
    input  wire logic         load_i,
    input  wire logic [W-1:0] data_i,
    // Data to the fabric
    output logic      [W-1:0] data_o
);

    // ------------------------------------------------------------
    // Reset selection
    // ------------------------------------------------------------
    // Async clear is gated from the port inputs; the fabric must keep it glitch free
    wire logic arst_w = rst_i | (~SYNC_RESET & clr_i);              // [R13]
    wire logic sclr_w = SYNC_RESET & clr_i;                         // [R13]

    logic [W-1:0] lat_q;
    logic [W-1:0] out_q;

    // ------------------------------------------------------------
    // Latch and register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge arst_w) begin
        if (arst_w) begin
            lat_q <= '0;
        end else if (sclr_w) begin
            lat_q <= '0;
        end else if (load_i) begin
            lat_q <= data_i;
        end
    end

    always_ff @(posedge clk_i or posedge arst_w) begin
        if (arst_w) begin
            out_q <= '0;
        end else if (sclr_w) begin
            out_q <= '0;
        end else begin
            out_q <= lat_q;
        end
    end

    assign data_o = OUT_REG ? out_q : lat_q;                        // [R9] [R16]

endmodule

// *** bench/bram_core_assertions.sv ***
// Port-level checker for the block RAM core
module bram_core_assertions
    import bram_pkg::*;
#(
    parameter int WIDTH_A = 9,
    parameter int WIDTH_B = 9,
    // Properties below assume true dual port, write-through A, no A out reg, async clears
    parameter bit CFG_OK  = 1'b1
) (
    // Clock and resets
    input wire logic                 ref_clk_i,
    input wire logic                 rst_i,
    input wire logic                 global_set_reset_n_i,
    input wire logic                 port_a_output_reset_i,
    input wire logic                 port_b_output_reset_i,
    // Requests and read data
    input wire bram_pkg::bram_req_t  port_a_req_i,
    input wire bram_pkg::bram_req_t  port_b_req_i,
    input wire logic [DATA_W-1:0]    port_a_rdata_o,
    input wire logic [DATA_W-1:0]    port_b_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [DATA_W-1:0] MASK_A = (36'h1 << WIDTH_A) - 36'h1;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i || !CFG_OK);
    a_glob_clear_both: assert property (
        !global_set_reset_n_i |-> port_a_rdata_o == '0 && port_b_rdata_o == '0)
        else $error("global clear left data");
    a_local_a_clear: assert property (
        port_a_output_reset_i |-> port_a_rdata_o == '0) else $error("port A clear missed");
    a_local_b_clear: assert property (
        port_b_output_reset_i |-> port_b_rdata_o == '0) else $error("port B clear missed");
    a_local_b_only: assert property (
        port_b_output_reset_i && global_set_reset_n_i && !port_a_output_reset_i
        && !$past(port_a_req_i.en, 2) |-> $stable(port_a_rdata_o))
        else $error("port B clear disturbed port A");
    a_upper_bits_zero: assert property (
        (port_a_rdata_o >> WIDTH_A) == '0 && (port_b_rdata_o >> WIDTH_B) == '0)
        else $error("bits above port width set");
    a_through_two: assert property (
        port_a_req_i.en && port_a_req_i.we ##1
        (global_set_reset_n_i && !port_a_output_reset_i)[*2]
        |-> port_a_rdata_o == ($past(port_a_req_i.wdata, 2) & MASK_A))
        else $error("write data not shown on port A");
    a_write_readback: assert property (
        port_a_req_i.en && port_a_req_i.we ##1 port_a_req_i.en && !port_a_req_i.we
        && port_a_req_i.addr == $past(port_a_req_i.addr)
        ##1 (global_set_reset_n_i && !port_a_output_reset_i)[*2]
        |-> port_a_rdata_o == ($past(port_a_req_i.wdata, 3) & MASK_A))
        else $error("read after write returned stale data");
    a_a_idle_hold: assert property (
        !port_a_req_i.en ##1 !port_a_req_i.en |=> $stable(port_a_rdata_o)
        || !global_set_reset_n_i || port_a_output_reset_i) else $error("port A moved idle");
    a_b_reg_hold: assert property (
        !port_b_req_i.en [*3] |=> $stable(port_b_rdata_o)
        || !global_set_reset_n_i || port_b_output_reset_i) else $error("port B moved idle");
endmodule

bind bram_core bram_core_assertions #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B),
    .CFG_OK(MODE == MODE_TRUE_DUAL && WRITE_MODE_A == WR_THROUGH && !OUT_REG_A
        && !SYNC_RESET)) chk_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .global_set_reset_n_i(global_set_reset_n_i),
    .port_a_output_reset_i(port_a_output_reset_i), .port_a_req_i(port_a_req_i),
    .port_b_output_reset_i(port_b_output_reset_i), .port_b_req_i(port_b_req_i),
    .port_a_rdata_o(port_a_rdata_o), .port_b_rdata_o(port_b_rdata_o));

// *** bench/bram_fabric.sv ***
// Fabric user logic presenting requests to one memory port
module bram_fabric
    import bram_pkg::*;
(
    // Request towards the port
    output bram_pkg::bram_req_t req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle cycles scramble the qualifiers, so logic that ignores en shows up
    task automatic put(input logic en, input logic we, input logic [ADDR_W-1:0] addr,
                       input logic [DATA_W-1:0] wdata);
        if (en) begin
            req_o = '{en: 1'b1, we: we, addr: addr, wdata: wdata};
        end else begin
            req_o = '{en: 1'b0, we: ~req_o.we, addr: ~req_o.addr, wdata: ~req_o.wdata};
        end
    endtask
    initial req_o = '0;
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the block RAM core
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bram_pkg::*;
    typedef struct {int due; logic [DATA_W-1:0] val;} bram_note_t;
    localparam logic [MEM_BITS-1:0] INIT = {256{36'h9A5C31E70}};
    logic ref_clk_i = 1'b0, rst_i = 1'b1, gsr_n = 1'b1, rst_a = 1'b0, rst_b = 1'b0;
    bram_req_t req_a, req_b;
    logic [DATA_W-1:0] rd_a, rd_b;
    logic [MEM_BITS-1:0] shadow = INIT;
    bram_note_t q_a[$], q_b[$];
    // Second instance: single port, x36, normal writes, output register, synchronous clears
    bram_req_t req_s;
    logic clr_s = 1'b0;
    logic [DATA_W-1:0] rd_s, rd_sb, last_s = '0;
    logic [MEM_BITS-1:0] shadow_s = INIT;
    bram_note_t q_s[$];
    int cyc = 0, err_total = 0, comparisons = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) cyc <= cyc + 1;
    bram_fabric fabric_a (.req_o(req_a));
    bram_fabric fabric_b (.req_o(req_b));
    bram_fabric fabric_s (.req_o(req_s));
    bram_core #(.MODE(MODE_TRUE_DUAL), .WIDTH_A(9), .WIDTH_B(18), .OUT_REG_A(1'b0),
        .OUT_REG_B(1'b1), .WRITE_MODE_A(WR_THROUGH), .WRITE_MODE_B(WR_READ_BEFORE),
        .SYNC_RESET(1'b0), .INIT_BITS(INIT)) bram_core_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .global_set_reset_n_i(gsr_n),
        .port_a_output_reset_i(rst_a), .port_b_output_reset_i(rst_b),
        .port_a_req_i(req_a), .port_b_req_i(req_b),
        .port_a_rdata_o(rd_a), .port_b_rdata_o(rd_b));
    // Port B of the single-port copy sees live traffic that it must ignore
    if (1'b1) begin : g_single
        bram_core #(.MODE(MODE_SINGLE), .WIDTH_A(36), .WIDTH_B(9), .OUT_REG_A(1'b1),
            .OUT_REG_B(1'b0), .WRITE_MODE_A(WR_NORMAL), .WRITE_MODE_B(WR_NORMAL),
            .SYNC_RESET(1'b1), .INIT_BITS(INIT)) bram_core_i (
            .ref_clk_i(ref_clk_i), .rst_i(rst_i), .global_set_reset_n_i(gsr_n),
            .port_a_output_reset_i(clr_s), .port_b_output_reset_i(rst_b),
            .port_a_req_i(req_s), .port_b_req_i(req_b),
            .port_a_rdata_o(rd_s), .port_b_rdata_o(rd_sb));
    end
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One cycle on both ports; A answers two edges later, B three (output register)
    task automatic step(input logic ae, aw, input int aad, input logic [8:0] ad,
                        input logic be, bw, input int bad, input logic [17:0] bd);
        @(negedge ref_clk_i);
        fabric_a.put(ae, aw, 13'(aad), 36'(ad));
        fabric_b.put(be, bw, 13'(bad), 36'(bd));
        if (ae) begin
            q_a.push_back('{cyc + 2, aw ? 36'(ad) : 36'(shadow[aad*9 +: 9])});
            if (aw) shadow[aad*9 +: 9] = ad;
        end
        if (be) begin
            q_b.push_back('{cyc + 3, 36'(shadow[bad*18 +: 18])});
            if (bw) shadow[bad*18 +: 18] = bd;
        end
    endtask
    task automatic idle(input int n);
        repeat (n) step(1'b0, 1'b0, 0, '0, 1'b0, 1'b0, 0, '0);
    endtask
    // Single-port copy: a normal write leaves the last read word on the output
    task automatic step_s(input logic e, w, input int ad, input logic [DATA_W-1:0] d);
        @(negedge ref_clk_i);
        fabric_s.put(e, w, 13'(ad), d);
        if (e) begin
            if (!w) last_s = shadow_s[ad*36 +: 36];
            q_s.push_back('{cyc + 3, last_s});
            if (w) shadow_s[ad*36 +: 36] = d;
        end
    endtask
    always @(negedge ref_clk_i) begin
        if (q_a.size() > 0 && q_a[0].due == cyc) begin
            check(rd_a, q_a[0].val);
            void'(q_a.pop_front());
        end
        if (q_b.size() > 0 && q_b[0].due == cyc) begin
            check(rd_b, q_b[0].val);
            void'(q_b.pop_front());
        end
        if (q_s.size() > 0 && q_s[0].due == cyc) begin
            check(rd_s, q_s[0].val);
            check(rd_sb, '0);
            void'(q_s.pop_front());
        end
    end
    always @(posedge ref_clk_i) if (cyc > 2000) begin
        err_total++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h72CF55EC));
        repeat (10) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        check(rd_b, '0);
        for (int k = 0; k < 8; k++) step(1'b1, 1'b0, k * 37, '0, 1'b1, 1'b0, 300 + k, '0);
        step(1'b1, 1'b1, 5, 9'h1A5, 1'b1, 1'b1, 400, 18'h2F0F0);
        step(1'b1, 1'b0, 5, '0, 1'b1, 1'b1, 400, 18'h0ABCD);
        step(1'b1, 1'b1, 40, 9'h0C3, 1'b1, 1'b0, 400, '0);
        idle(1);
        step(1'b0, 1'b0, 0, '0, 1'b1, 1'b0, 20, '0);
        // A keeps to words 0-511 and B to 256-511, so the two never contend
        repeat (200) step(1'($urandom), 1'($urandom), $urandom_range(511), 9'($urandom),
            1'($urandom), 1'($urandom), $urandom_range(511, 256), 18'($urandom));
        step(1'b1, 1'b0, 5, '0, 1'b1, 1'b0, 300, '0);
        idle(4);
        rst_a = 1'b1;
        #1 check(rd_a, '0);
        check(rd_b, 36'(shadow[300*18 +: 18]));
        @(negedge ref_clk_i);
        rst_a = 1'b0;
        rst_b = 1'b1;
        #1 check(rd_b, '0);
        @(negedge ref_clk_i);
        rst_b = 1'b0;
        step(1'b1, 1'b0, 5, '0, 1'b1, 1'b0, 300, '0);
        idle(4);
        gsr_n = 1'b0;
        #1 check(rd_a | rd_b, '0);
        @(negedge ref_clk_i);
        gsr_n = 1'b1;
        idle(4);
        step_s(1'b1, 1'b0, 3, '0);
        step_s(1'b1, 1'b1, 3, 36'h123456789);
        step_s(1'b1, 1'b0, 3, '0);
        repeat (40) step_s(1'b1, 1'($urandom), $urandom_range(255),
            36'({$urandom, $urandom}));
        repeat (4) step_s(1'b0, 1'b0, 0, '0);
        // Synchronous clear waits for the edge, then empties both output stages
        clr_s = 1'b1;
        #1 check(rd_s, last_s);
        @(negedge ref_clk_i);
        clr_s = 1'b0;
        check(rd_s, '0);
        print_verdict();
    end
endmodule
